/* devctl_pkg.sv */
package devctl_pkg;
    // One machine cycle is twelve oscillator periods.
    localparam int unsigned OSC_PER_MCYCLE = 12;
    localparam int unsigned RESET_MCYCLES = 2;
    localparam int unsigned RESET_OSC_MIN = OSC_PER_MCYCLE * RESET_MCYCLES;
    localparam logic [4:0] RESET_OSC_MIN_C = 5'(RESET_OSC_MIN);
    localparam int unsigned ENTRY_BITS = 10;
    // Bit 0 must be 0: the falling pin that opens a frame is bit 0.
    localparam logic [9:0] ENTRY_PATTERN_DEF = 10'h2a4;
    localparam int unsigned ADDR_BITS = 10;
    localparam int unsigned HIGH_ADDR_BITS = 3;
    localparam int unsigned PWR_IDLE_BIT = 0;
    localparam int unsigned PWR_DOWN_BIT = 1;
    localparam logic [1:0] PWR_CTRL_RESET = 2'h0;
    localparam logic [7:0] PORT_RESET = 8'hff;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RUN = 3'b001,
        ST_IDLE = 3'b010,
        ST_POWERDOWN = 3'b011,
        ST_PROGRAM = 3'b100
    } mode_e;
endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree.
module pin_sync (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level = level_q;
endmodule // pin_sync

/* devctl.sv */
`timescale 1ns/1ps
// What this block does
// [RULE1] Reset after pin high 24 oscillator periods
// [RULE2] Source holds reset through oscillator start-up
// [RULE3] Core clock is oscillator divided by two
// [RULE4] Ten-bit serial pattern after reset enters programming
// [RULE5] Pattern bits strobed by oscillator input edges
// [RULE6] Select high gives verify, low gives program
// [RULE7] Byte select picks low byte or three bits; the code latches only two high bits
// [RULE8] Address built from two port 3 transfers
// [RULE9] Verify drives port 1; program reads port 1
// [RULE10] Idle halts core, peripherals keep running
// [RULE11] Idle starts right after requesting instruction
// [RULE12] Interrupt or reset ends idle
// [RULE13] Power-down stops oscillator, keeps RAM
// [RULE14] Only reset ends power-down
// [RULE15] Power control bits request idle, power-down
// [RULE16] Entry pattern is a design parameter
// [RULE17] Machine cycle counts twelve oscillator periods
module devctl #(
    parameter logic [9:0] ENTRY_PATTERN = devctl_pkg::ENTRY_PATTERN_DEF
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic osc_input,
    input wire logic reset_pin,
    input wire logic verify_program_select,
    input wire logic address_byte_select,
    input wire logic [7:0] port3_in,
    input wire logic [7:0] port1_in,
    input wire logic [7:0] eprom_rdata,
    input wire logic pwr_ctrl_wr,
    input wire logic [1:0] pwr_ctrl_wdata,
    input wire logic instr_done,
    input wire logic irq_pending,
    output logic core_reset,
    output logic core_clk_en,
    output logic core_halt,
    output logic osc_stop,
    output logic periph_clk_en,
    output logic [1:0] power_control_reg,
    output logic prog_state,
    output logic verify_mode,
    output logic [9:0] eprom_addr,
    output logic eprom_wr,
    output logic [7:0] eprom_wdata,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe
);
    logic osc_s;
    logic rst_s;
    logic vps_s;
    logic bsel_s;

    pin_sync u_osc (.clock(clock), .arst_n(arst_n), .pin(osc_input),
        .level(osc_s));
    pin_sync u_rst (.clock(clock), .arst_n(arst_n), .pin(reset_pin),
        .level(rst_s));
    pin_sync u_vps (.clock(clock), .arst_n(arst_n),
        .pin(verify_program_select), .level(vps_s));
    pin_sync u_bsel (.clock(clock), .arst_n(arst_n),
        .pin(address_byte_select), .level(bsel_s));

    devctl_pkg::mode_e mode_q, mode_d;
    logic osc_prev_q;
    logic div_q;
    logic [4:0] hold_cnt_q;
    logic rst_prev_q;
    logic [9:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [1:0] pwr_q;
    logic [9:0] addr_q;
    logic bsel_prev_q;
    logic core_reset_q, core_clk_en_q, core_halt_q, osc_stop_q;
    logic periph_clk_en_q, prog_q, verify_q, eprom_wr_q;
    logic [7:0] wdata_q, p1_out_q, p1_oe_q;

    wire osc_rise = osc_s && !osc_prev_q;
    wire osc_run = (mode_q != devctl_pkg::ST_POWERDOWN);
    wire osc_tick = osc_rise && osc_run;
    // Reset qualification counts oscillator periods, not core cycles.
    wire reset_qual =
        (hold_cnt_q >= devctl_pkg::RESET_OSC_MIN_C); // RULE1 RULE17
    wire rst_fall = rst_prev_q && !rst_s;
    wire entry_match = (shift_q == ENTRY_PATTERN) &&
        (bit_cnt_q == 4'(devctl_pkg::ENTRY_BITS)); // RULE16
    // A full frame without a match, or a pin that was already low at the
    // first counted edge, releases the core.
    wire entry_miss = (bit_cnt_q == 4'(devctl_pkg::ENTRY_BITS)) &&
        !entry_match;
    wire pin_low_idle = osc_tick && !rst_s && !rst_prev_q &&
        (bit_cnt_q == 4'h0);
    wire req_idle = pwr_q[devctl_pkg::PWR_IDLE_BIT];
    wire req_pd = pwr_q[devctl_pkg::PWR_DOWN_BIT];
    wire bsel_edge = bsel_s != bsel_prev_q;
    wire div_tick = osc_tick && div_q; // RULE3

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            devctl_pkg::ST_RESET: begin
                if (entry_match) begin
                    mode_d = devctl_pkg::ST_PROGRAM; // RULE4
                end else if (entry_miss || pin_low_idle) begin
                    mode_d = devctl_pkg::ST_RUN; // RULE4
                end
            end
            devctl_pkg::ST_RUN: begin
                // Power-down wins if software sets both bits.
                if (instr_done && req_pd) begin
                    mode_d = devctl_pkg::ST_POWERDOWN; // RULE13
                end else if (instr_done && req_idle) begin
                    mode_d = devctl_pkg::ST_IDLE; // RULE11
                end
            end
            devctl_pkg::ST_IDLE: begin
                if (irq_pending) begin
                    mode_d = devctl_pkg::ST_RUN; // RULE12
                end
            end
            devctl_pkg::ST_POWERDOWN: begin
                mode_d = devctl_pkg::ST_POWERDOWN; // RULE14
            end
            devctl_pkg::ST_PROGRAM: mode_d = devctl_pkg::ST_PROGRAM;
            default: mode_d = devctl_pkg::ST_RESET;
        endcase
        if (reset_qual && mode_q != devctl_pkg::ST_PROGRAM) begin
            mode_d = devctl_pkg::ST_RESET; // RULE12 RULE14
        end
        // Power-down has no oscillator; the raw synchronised pin ends it.
        if (mode_q == devctl_pkg::ST_POWERDOWN && rst_s) begin
            mode_d = devctl_pkg::ST_RESET; // RULE14
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= devctl_pkg::ST_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_prev_q <= 1'b0;
            div_q <= 1'b0;
            hold_cnt_q <= 5'h0;
        end else begin
            osc_prev_q <= osc_s;
            if (osc_tick) begin
                div_q <= !div_q; // RULE3
            end
            if (!rst_s) begin
                hold_cnt_q <= 5'h0;
            end else if (osc_tick && !reset_qual) begin
                hold_cnt_q <= hold_cnt_q + 5'h1; // RULE1
            end
        end
    end

    // Entry bits are shifted in LSB first, one per oscillator rising edge.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_prev_q <= 1'b0;
            shift_q <= 10'h0;
            bit_cnt_q <= 4'h0;
        end else begin
            if (osc_tick) begin
                rst_prev_q <= rst_s;
            end
            if (mode_q != devctl_pkg::ST_RESET) begin
                bit_cnt_q <= 4'h0;
            end else if (osc_tick && rst_fall && bit_cnt_q == 4'h0) begin
                bit_cnt_q <= 4'h1;
                shift_q <= {rst_s, 9'h0};
            end else if (osc_tick && bit_cnt_q != 4'h0 &&
                    bit_cnt_q < 4'(devctl_pkg::ENTRY_BITS)) begin
                shift_q <= {rst_s, shift_q[9:1]}; // RULE4 RULE5
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pwr_q <= devctl_pkg::PWR_CTRL_RESET;
        end else if (mode_q == devctl_pkg::ST_RESET) begin
            pwr_q <= devctl_pkg::PWR_CTRL_RESET;
        end else if (mode_d == devctl_pkg::ST_RUN &&
                mode_q != devctl_pkg::ST_RUN) begin
            pwr_q[devctl_pkg::PWR_IDLE_BIT] <= 1'b0;
        end else if (pwr_ctrl_wr) begin
            pwr_q <= pwr_ctrl_wdata; // RULE15
        end
    end

    // Address follows port 3 every cycle in programming; the byte select level picks the half.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= 10'h0;
            bsel_prev_q <= 1'b0;
        end else begin
            bsel_prev_q <= bsel_s;
            if (prog_q) begin
                if (!bsel_s) begin
                    addr_q[7:0] <= port3_in; // RULE7 RULE8
                end else begin
                    addr_q[9:8] <= port3_in[1:0]; // RULE7 RULE8
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            core_reset_q <= 1'b1;
            core_clk_en_q <= 1'b0;
            core_halt_q <= 1'b0;
            osc_stop_q <= 1'b0;
            periph_clk_en_q <= 1'b0;
            prog_q <= 1'b0;
            verify_q <= 1'b0;
            eprom_wr_q <= 1'b0;
            wdata_q <= 8'h0;
            p1_out_q <= devctl_pkg::PORT_RESET;
            p1_oe_q <= 8'h0;
        end else begin
            core_reset_q <= (mode_d == devctl_pkg::ST_RESET);
            core_halt_q <= (mode_d == devctl_pkg::ST_IDLE) ||
                (mode_d == devctl_pkg::ST_POWERDOWN); // RULE10
            core_clk_en_q <= div_tick && (mode_q == devctl_pkg::ST_RUN);
            periph_clk_en_q <= div_tick && (mode_q == devctl_pkg::ST_RUN ||
                mode_q == devctl_pkg::ST_IDLE); // RULE10
            osc_stop_q <= (mode_d == devctl_pkg::ST_POWERDOWN); // RULE13
            prog_q <= (mode_d == devctl_pkg::ST_PROGRAM);
            verify_q <= (mode_d == devctl_pkg::ST_PROGRAM) && vps_s; // RULE6
            eprom_wr_q <= (mode_q == devctl_pkg::ST_PROGRAM) && !vps_s &&
                bsel_edge; // RULE9
            wdata_q <= port1_in; // RULE9
            p1_out_q <= eprom_rdata; // RULE9
            p1_oe_q <= {8{(mode_d == devctl_pkg::ST_PROGRAM) && vps_s}};
        end
    end

    assign core_reset = core_reset_q;
    assign core_clk_en = core_clk_en_q;
    assign core_halt = core_halt_q;
    assign osc_stop = osc_stop_q;
    assign periph_clk_en = periph_clk_en_q;
    assign power_control_reg = pwr_q;
    assign prog_state = prog_q;
    assign verify_mode = verify_q;
    assign eprom_addr = addr_q;
    assign eprom_wr = eprom_wr_q;
    assign eprom_wdata = wdata_q;
    assign port1_out = p1_out_q;
    assign port1_oe = p1_oe_q;

    hold_reset_a: assert property (@(posedge clock) // RULE1
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_RUN && reset_qual) |=> core_reset)
        else $error("qualified reset pulse did not reset");
    short_pulse_a: assert property (@(posedge clock) // RULE17
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_RUN && !reset_qual && rst_s &&
        !entry_match) |=> mode_q != devctl_pkg::ST_RESET)
        else $error("reset taken before 24 periods");
    div_half_a: assert property (@(posedge clock) // RULE3
        disable iff (!arst_n)
        core_clk_en |-> $past(div_q, 2))
        else $error("core enable not on divided phase");
    prog_entry_a: assert property (@(posedge clock) // RULE4
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_RESET && entry_match) |=> prog_state)
        else $error("entry pattern did not enter programming");
    miss_run_a: assert property (@(posedge clock) // RULE4
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_RESET && entry_miss && !reset_qual) |=>
        !core_reset)
        else $error("unmatched entry frame kept the core in reset");
    verify_sel_a: assert property (@(posedge clock) // RULE6
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_PROGRAM && vps_s) |=> verify_mode &&
        port1_oe == 8'hff)
        else $error("verify mode not driving port 1");
    low_byte_a: assert property (@(posedge clock) // RULE7
        disable iff (!arst_n)
        (prog_q && !bsel_s) |=> eprom_addr[7:0] == $past(port3_in))
        else $error("low address byte not latched");
    idle_entry_a: assert property (@(posedge clock) // RULE11
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_RUN && instr_done && req_idle &&
        !req_pd && !reset_qual) |=> core_halt && !osc_stop)
        else $error("idle did not halt core");
    idle_wake_a: assert property (@(posedge clock) // RULE12
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_IDLE && irq_pending && !reset_qual)
        |=> !core_halt)
        else $error("interrupt did not end idle");
    pd_stay_a: assert property (@(posedge clock) // RULE14
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_POWERDOWN && !rst_s) |=>
        mode_q == devctl_pkg::ST_POWERDOWN)
        else $error("power-down left without reset");
    pd_request_a: assert property (@(posedge clock) // RULE15
        disable iff (!arst_n)
        (mode_q == devctl_pkg::ST_RUN && instr_done && req_pd &&
        !reset_qual) |=> osc_stop)
        else $error("power-down bit did not stop oscillator");

    idle_seen_c: cover property (@(posedge clock) disable iff (!arst_n)
        mode_q == devctl_pkg::ST_IDLE ##1 mode_q == devctl_pkg::ST_RUN);
    pd_seen_c: cover property (@(posedge clock) disable iff (!arst_n)
        mode_q == devctl_pkg::ST_POWERDOWN);
    prog_seen_c: cover property (@(posedge clock) disable iff (!arst_n)
        eprom_wr);
    miss_seen_c: cover property (@(posedge clock) disable iff (!arst_n)
        mode_q == devctl_pkg::ST_RESET && entry_miss);
endmodule // devctl

/* ext_programmer.sv */
`timescale 1ns/1ps
module ext_programmer (
    input wire logic clock,
    input wire logic osc_stop,
    output logic osc_input,
    output logic reset_pin
);
    logic [2:0] phase_q;
    initial begin
        phase_q = 3'h0;
        osc_input = 1'b0;
        reset_pin = 1'b1;
    end
    // The oscillator stands still while the device is powered down.
    always @(negedge clock) begin
        if (!osc_stop) begin
            phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
            osc_input <= (phase_q < 3'h3);
        end
    end
    // The pin changes only in the low half of an oscillator period.
    task automatic hold_pin(input logic v, input int n);
        reset_pin = v;
        repeat (n) @(negedge osc_input);
    endtask
    task automatic send_pattern(input logic [9:0] p);
        for (int i = 0; i < 10; i++) begin
            hold_pin(p[i], 1);
        end
        reset_pin = 1'b0;
    endtask
endmodule // ext_programmer

/* test_devctl.sv */
`timescale 1ns/1ps
module test_devctl;
    localparam logic [9:0] PATTERN = 10'h1b6;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic osc_input, reset_pin, verify_program_select, address_byte_select;
    logic [7:0] port3_in, port1_in, eprom_rdata, v, d;
    logic pwr_ctrl_wr, instr_done, irq_pending;
    logic [1:0] pwr_ctrl_wdata;
    logic core_reset, core_clk_en, core_halt, osc_stop, periph_clk_en;
    logic [1:0] power_control_reg;
    logic prog_state, verify_mode, eprom_wr;
    logic [9:0] eprom_addr;
    logic [7:0] eprom_wdata, port1_out, port1_oe;
    logic [17:0] exp_q[$];
    int n_mismatch = 0;
    int check_count = 0;
    int core_n, per_n;
    always #5 clock = ~clock;
    devctl #(.ENTRY_PATTERN(PATTERN)) devctl_inst (.clock(clock),
        .arst_n(arst_n), .osc_input(osc_input), .reset_pin(reset_pin),
        .verify_program_select(verify_program_select),
        .address_byte_select(address_byte_select), .port3_in(port3_in),
        .port1_in(port1_in), .eprom_rdata(eprom_rdata),
        .pwr_ctrl_wr(pwr_ctrl_wr), .pwr_ctrl_wdata(pwr_ctrl_wdata),
        .instr_done(instr_done),
        .irq_pending(irq_pending), .core_reset(core_reset),
        .core_clk_en(core_clk_en), .core_halt(core_halt),
        .osc_stop(osc_stop), .periph_clk_en(periph_clk_en),
        .power_control_reg(power_control_reg), .prog_state(prog_state),
        .verify_mode(verify_mode), .eprom_addr(eprom_addr),
        .eprom_wr(eprom_wr), .eprom_wdata(eprom_wdata),
        .port1_out(port1_out), .port1_oe(port1_oe));
    ext_programmer ext_programmer_inst (.clock(clock), .osc_stop(osc_stop),
        .osc_input(osc_input), .reset_pin(reset_pin));
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic pulse(input logic [1:0] w, input logic instr);
        pwr_ctrl_wr = ~instr;
        pwr_ctrl_wdata = w;
        instr_done = instr;
        cycles(1);
        pwr_ctrl_wr = 1'b0;
        instr_done = 1'b0;
    endtask
    // Port 3 is held across the toggle, so both address halves are known.
    task automatic prog_write(input logic [7:0] a, input logic [7:0] b);
        port3_in = a;
        port1_in = b;
        cycles(6);
        exp_q.push_back({a[1:0], a, b});
        address_byte_select = ~address_byte_select;
        cycles(8);
    endtask
    // Counts enable pulses; the bench clears the counts between windows.
    always @(posedge clock) begin
        core_n += int'(core_clk_en === 1'b1);
        per_n += int'(periph_clk_en === 1'b1);
    end
    always @(posedge clock) begin
        #1;
        if (eprom_wr === 1'b1) begin
            if (exp_q.size() == 0)
                check(18'h0, 18'h1);
            else
                check({eprom_addr, eprom_wdata}, exp_q.pop_front());
        end
    end
    initial begin
        #(400_000);
        n_mismatch++;
        results();
    end
    initial begin
        {verify_program_select, address_byte_select, pwr_ctrl_wr} = 3'h0;
        {port3_in, port1_in, eprom_rdata} = 24'h0;
        {pwr_ctrl_wdata, instr_done, irq_pending} = 4'h0;
        void'($urandom(62));
        cycles(3);
        arst_n = 1'b1;
        ext_programmer_inst.hold_pin(1'b1, 30);
        check(18'(core_reset), 18'h1);
        ext_programmer_inst.send_pattern(PATTERN ^ 10'h200);
        cycles(20);
        check(18'(prog_state), 18'h0);
        check(18'(core_reset), 18'h0);
        ext_programmer_inst.hold_pin(1'b1, 21);
        ext_programmer_inst.hold_pin(1'b0, 4);
        check(18'(core_reset), 18'h0);
        ext_programmer_inst.hold_pin(1'b1, 26);
        check(18'(core_reset), 18'h1);
        ext_programmer_inst.hold_pin(1'b0, 12);
        check(18'(core_reset), 18'h0);
        core_n = 0;
        cycles(72);
        check(18'(core_n >= 5 && core_n <= 7), 18'h1);
        pulse(2'h1, 1'b0);
        cycles(3);
        check({power_control_reg, core_halt}, 18'h2);
        pulse(2'h1, 1'b1);
        cycles(2);
        core_n = 0;
        per_n = 0;
        cycles(48);
        check({core_halt, 8'(core_n), per_n > 0}, 18'h201);
        irq_pending = 1'b1;
        cycles(3);
        check({power_control_reg, core_halt}, 18'h0);
        irq_pending = 1'b0;
        pulse(2'h3, 1'b0);
        cycles(1);
        pulse(2'h0, 1'b1);
        cycles(3);
        check({osc_stop, core_halt}, 18'h3);
        irq_pending = 1'b1;
        cycles(6);
        check({osc_stop, core_halt}, 18'h3);
        irq_pending = 1'b0;
        ext_programmer_inst.reset_pin = 1'b1;
        cycles(8);
        check({core_reset, osc_stop}, 18'h2);
        ext_programmer_inst.hold_pin(1'b1, 30);
        ext_programmer_inst.send_pattern(PATTERN);
        cycles(20);
        check(18'(prog_state), 18'h1);
        verify_program_select = 1'b1;
        v = 8'($urandom());
        d = 8'($urandom());
        port3_in = v;
        cycles(6);
        address_byte_select = 1'b1;
        cycles(6);
        port3_in = d;
        eprom_rdata = ~d;
        cycles(3);
        check({eprom_addr, verify_mode}, {d[1:0], v, 1'b1});
        check({port1_out, port1_oe}, {~d, 8'hff});
        verify_program_select = 1'b0;
        cycles(6);
        check({verify_mode, port1_oe}, 18'h0);
        for (int i = 0; i < 5; i++) begin
            prog_write(8'($urandom()), 8'($urandom()));
        end
        check(18'(exp_q.size()), 18'h0);
        results();
    end
endmodule // test_devctl
